// ===== scc_baud.sv
// baud divider: one tick per half serial clock period
`timescale 1ns/100ps
module scc_baud (
    // clock and reset
    input  wire logic clk,
    input  wire logic nrst,
    // link
    scc_link_if.baud  lk
);
    logic [11:0] cnt_q;
    logic [11:0] half_w;

    // half divisor = (presel+1) * 2^sel
    assign half_w = 12'((({9'h000, lk.presel} + 12'h001)) << lk.sel);

    // free count while a master transfer runs
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cnt_q <= 12'h000;
        end else if (!lk.enable || !lk.master || lk.abort || !lk.busy ||
                     !lk.clk_run) begin
            cnt_q <= (!lk.clk_run && lk.busy && !lk.abort) ? cnt_q : 12'h000;
        end else if (cnt_q == half_w - 12'h001) begin
            cnt_q <= 12'h000;
        end else begin
            cnt_q <= cnt_q + 12'h001;
        end
    end

    assign lk.baud_tick = lk.enable && lk.master && lk.busy && lk.clk_run &&
                          !lk.abort && (cnt_q == half_w - 12'h001);
endmodule

// ===== scc_link_if.sv
// carrier between the control top and its helper modules
`timescale 1ns/100ps
interface scc_link_if;
    logic       enable;
    logic       master;
    logic       clock_polarity;
    logic       clock_phase;
    logic       lsb_first;
    logic       wide;
    logic       abort;
    logic       clk_run;
    logic [2:0] presel;
    logic [2:0] sel;
    logic       baud_tick;
    logic       busy;
    logic       done;
    logic [15:0] tx_word;
    logic       tx_load;
    logic [15:0] rx_word;
    logic       sck_o;
    logic       sdo;
    logic       sdi;
    modport ctrl (output enable, master, clock_polarity, clock_phase, lsb_first, wide, abort,
                  clk_run, presel, sel, tx_word, tx_load, sdi,
                  input baud_tick, busy, done, rx_word, sck_o, sdo);
    modport baud (input enable, master, abort, clk_run, presel, sel, busy,
                  output baud_tick);
    modport shift (input enable, master, clock_polarity, clock_phase, lsb_first, wide, abort,
                   baud_tick, tx_word, tx_load, sdi,
                   output busy, done, rx_word, sck_o, sdo);
endinterface

// ===== scc_pkg.sv
// shared constants for the serial port control block
package scc_pkg;
    // register offsets (byte addresses, low 8 bits of the map)
    localparam logic [7:0] ADDR_CTRL_ONE  = 8'he8;
    localparam logic [7:0] ADDR_CTRL_TWO  = 8'he9;
    localparam logic [7:0] ADDR_BAUD      = 8'hea;
    localparam logic [7:0] ADDR_STATUS    = 8'heb;
    localparam logic [7:0] ADDR_IRQ_MASK  = 8'hf0;
    localparam logic [7:0] ADDR_IRQ_STAT  = 8'hf1;
    // control one fields
    localparam int C1_RXF_IE   = 7;
    localparam int C1_EN       = 6;
    localparam int C1_TXE_IE   = 5;
    localparam int C1_MASTER   = 4;
    localparam int C1_CLOCK_POLARITY     = 3;
    localparam int C1_CLOCK_PHASE     = 2;
    localparam int C1_SELECT_OUTPUT_ENABLE     = 1;
    localparam int C1_LSBF     = 0;
    // control two fields
    localparam int C2_WIDTH    = 6;
    localparam int C2_MODE_FAULT_ENABLE   = 4;
    localparam int C2_BIDIR_OUTPUT_ENABLE  = 3;
    localparam int C2_WAITSTOP = 1;
    localparam int C2_PINCTL   = 0;
    localparam logic [7:0] C2_IMPL_MASK = 8'h5b;
    localparam logic [7:0] BAUD_IMPL_MASK = 8'h77;
    // status fields
    localparam int ST_DONE     = 7;
    localparam int ST_TXE      = 5;
    localparam int ST_MODE_FAULT_FLAG     = 4;
    // interrupt status bits
    localparam int IRQ_DONE    = 0;
    localparam int IRQ_TXE     = 1;
    localparam int IRQ_MODE_FAULT_FLAG    = 2;
    localparam logic [7:0] IRQ_IMPL_MASK = 8'h07;
    // reset values
    localparam logic [7:0] CTRL_ONE_RST = 8'h04;
    localparam logic [7:0] CTRL_TWO_RST = 8'h00;
    localparam logic [7:0] BAUD_RST     = 8'h00;
endpackage

// ===== scc_shift.sv
// master shifter: serial clock, bit order, width and abort
`timescale 1ns/100ps
module scc_shift (
    // clock and reset
    input  wire logic clk,
    input  wire logic nrst,
    // link
    scc_link_if.shift lk
);
    logic [15:0] sh_q;
    logic [5:0]  edge_q;
    logic        busy_q;
    logic        done_q;
    logic        sck_q;
    logic        sample_q;
    logic [15:0] rx_q;
    logic [5:0]  last_w;
    logic        last_bit;

    assign last_w = lk.wide ? 6'd32 : 6'd16;
    // phase 1 samples its final bit on the closing edge itself
    assign last_bit = lk.clock_phase ? lk.sdi : sample_q;

    // transfer sequencing, edges counted from 1
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sh_q     <= 16'h0000;
            edge_q   <= 6'd0;
            busy_q   <= 1'b0;
            done_q   <= 1'b0;
            sck_q    <= 1'b0;
            sample_q <= 1'b0;
            rx_q     <= 16'h0000;
        end else begin
            done_q <= 1'b0;
            if (!lk.enable || !lk.master || lk.abort) begin
                busy_q <= 1'b0;
                edge_q <= 6'd0;
                sck_q  <= 1'b0;
            end else if (lk.tx_load && !busy_q) begin
                sh_q   <= lk.tx_word;
                busy_q <= 1'b1;
                edge_q <= 6'd0;
            end else if (busy_q && lk.baud_tick) begin
                edge_q <= edge_q + 6'd1;
                sck_q  <= ~sck_q;
                // odd edges sample when phase 0, even edges when phase 1
                if ((edge_q[0] == 1'b0) != lk.clock_phase) begin
                    sample_q <= lk.sdi;
                end else if (edge_q != 6'd0) begin
                    // phase 1 keeps the first bit standing over edge one
                    sh_q <= lk.lsb_first ? {sample_q, sh_q[15:1]}
                                         : {sh_q[14:0], sample_q};
                end
                if (edge_q + 6'd1 == last_w) begin
                    busy_q <= 1'b0;
                    done_q <= 1'b1;
                    sck_q  <= 1'b0;
                    if (lk.lsb_first) begin
                        // lsb-first samples enter from the top end
                        rx_q <= lk.wide ? {last_bit, sh_q[15:1]}
                                        : {8'h00, last_bit, sh_q[15:9]};
                    end else begin
                        rx_q <= lk.wide ? {sh_q[14:0], last_bit}
                                        : {8'h00, sh_q[6:0], last_bit};
                    end
                end
            end
        end
    end

    assign lk.busy    = busy_q;
    assign lk.done    = done_q;
    assign lk.rx_word = rx_q;
    assign lk.sck_o   = sck_q ^ lk.clock_polarity;
    // msb-first output of an 8-bit word leaves from bit 7
    assign lk.sdo     = lk.lsb_first ? sh_q[0]
                      : (lk.wide ? sh_q[15] : sh_q[7]);
endmodule

// ===== scc_slave_model.sv
// behavioural serial slave on the far side of the port
`timescale 1ns/100ps
module scc_slave_model (
    // serial pins
    input  wire logic        sck,
    input  wire logic        mosi,
    output logic             miso,
    // setup and capture
    input  wire logic        clock_polarity,
    input  wire logic        clock_phase,
    input  wire logic        clr,
    output logic      [15:0] word,
    output int               cnt
);
    logic last_sck;
    // answer line keeps changing so a stale bit never looks valid
    assign miso = ~word[0];
    // sample edge follows polarity and phase
    // only a real clock change counts, never the fall of clr
    always @(sck or clr) begin
        if (clr) begin
            word = 16'h0000;
            cnt  = 0;
        end else if (sck !== last_sck && (sck ^ clock_polarity ^ clock_phase)) begin
            word = {word[14:0], mosi};
            cnt++;
        end
        last_sck = sck;
    end
endmodule

// ===== scc_top.sv
// serial port control registers with pin steering and interrupts
// Summary of operation
// - control-one bit 7 gates done and mode-fault interrupt requests
// - bit 6 enables port and pins; clearing idles port, clears status
// - bit 5 gates transmit-empty interrupt requests
// - bit 4 picks slave or master; any role switch forces idle
// - bit 3 sets idle clock level; both ends must match
// - bit 2 phase: sample odd edges at 0, even edges at 1
// - bit 0 picks lsb-first shifting; data register layout unchanged
// - select pin use follows role, fault enable and output enable
// - master-mode changes of format bits abort transfer and idle
// - control-two bit 6 picks 8 or 16 bit transfers
// - bidir output enable drives out pin in single-wire use; master change then aborts
// - control-two bit 1 stops serial clock in wait mode
// - pin control bit picks normal or single-wire pin use
// - unimplemented control-two bits ignore writes
// - master bit rate is bus clock over baud divisor
// - unimplemented bits read as zero
`timescale 1ns/100ps
module scc_top (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       nrst,
    // register port
    input  wire logic [7:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic       wr,
    input  wire logic       rd,
    output logic      [7:0] rdata,
    // data words to and from the data register block
    input  wire logic [15:0] tx_data,
    input  wire logic       tx_write,
    output logic      [15:0] rx_data,
    // system
    input  wire logic       wait_mode,
    output logic            irq,
    // serial pins
    input  wire logic       mosi_i,
    output logic            mosi_o,
    output logic            mosi_oe,
    input  wire logic       miso_i,
    output logic            miso_o,
    output logic            miso_oe,
    input  wire logic       sck_i,
    output logic            sck_o,
    output logic            sck_oe,
    input  wire logic       ssel_n_i,
    output logic            ssel_n_o,
    output logic            ssel_n_oe
);
    scc_link_if lk ();

    logic [7:0] ctrl_one_q;
    logic [7:0] ctrl_two_q;
    logic [7:0] baud_q;
    logic       done_flag_q;
    logic       txe_flag_q;
    logic       mode_fault_flag_flag_q;
    logic [7:0] irq_mask_q;
    logic [7:0] irq_stat_q;
    logic [7:0] rdata_q;
    logic [7:0] c1_d;
    logic [7:0] c2_d;
    logic [7:0] bd_d;
    logic       wr_c1;
    logic       wr_c2;
    logic       wr_bd;
    logic       fault_w;
    logic       abort_w;
    logic       pinctl;
    logic       master;
    logic       fault_in_mode;

    // write decode
    assign wr_c1 = wr && (addr == scc_pkg::ADDR_CTRL_ONE);
    assign wr_c2 = wr && (addr == scc_pkg::ADDR_CTRL_TWO);
    assign wr_bd = wr && (addr == scc_pkg::ADDR_BAUD);
    assign master = ctrl_one_q[scc_pkg::C1_MASTER];
    assign pinctl = ctrl_two_q[scc_pkg::C2_PINCTL];

    assign fault_in_mode = master && ctrl_two_q[scc_pkg::C2_MODE_FAULT_ENABLE] &&
                           !ctrl_one_q[scc_pkg::C1_SELECT_OUTPUT_ENABLE];
    assign fault_w = ctrl_one_q[scc_pkg::C1_EN] && fault_in_mode &&
                     !ssel_n_i;

    // next values of the control registers
    always_comb begin
        c1_d = wr_c1 ? wdata : ctrl_one_q;
        c2_d = wr_c2 ? (wdata & scc_pkg::C2_IMPL_MASK) : ctrl_two_q;
        bd_d = wr_bd ? (wdata & scc_pkg::BAUD_IMPL_MASK) : baud_q;
        if (fault_w) begin
            c1_d[scc_pkg::C1_MASTER] = 1'b0;
        end
    end

    always_comb begin
        abort_w = (c1_d[scc_pkg::C1_MASTER] != master) ||
                  !c1_d[scc_pkg::C1_EN];
        if (master) begin
            abort_w = abort_w ||
                (c1_d[3:0] != ctrl_one_q[3:0]) ||
                (c2_d[scc_pkg::C2_WIDTH] != ctrl_two_q[scc_pkg::C2_WIDTH]) ||
                (c2_d[scc_pkg::C2_MODE_FAULT_ENABLE] !=
                 ctrl_two_q[scc_pkg::C2_MODE_FAULT_ENABLE]) ||
                (c2_d[scc_pkg::C2_PINCTL] != pinctl) ||
                (pinctl && (c2_d[scc_pkg::C2_BIDIR_OUTPUT_ENABLE] !=
                            ctrl_two_q[scc_pkg::C2_BIDIR_OUTPUT_ENABLE])) ||
                (bd_d != baud_q);
        end
    end

    // control register storage
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ctrl_one_q <= scc_pkg::CTRL_ONE_RST;
            ctrl_two_q <= scc_pkg::CTRL_TWO_RST;
            baud_q     <= scc_pkg::BAUD_RST;
        end else begin
            ctrl_one_q <= c1_d;
            ctrl_two_q <= c2_d;
            baud_q     <= bd_d;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            done_flag_q <= 1'b0;
            txe_flag_q  <= 1'b0;
            mode_fault_flag_flag_q <= 1'b0;
        end else if (!ctrl_one_q[scc_pkg::C1_EN]) begin
            done_flag_q <= 1'b0;
            txe_flag_q  <= 1'b0;
            mode_fault_flag_flag_q <= 1'b0;
        end else begin
            // set wins over the read clear
            done_flag_q <= lk.done ||
                (done_flag_q && !(rd && addr == scc_pkg::ADDR_STATUS));
            txe_flag_q  <= (!lk.busy && !tx_write) ||
                (txe_flag_q && !tx_write);
            mode_fault_flag_flag_q <= fault_w ||
                (mode_fault_flag_flag_q && !(wr_c1 && !fault_w));
        end
    end

    // sticky interrupt status, write one to clear, set wins
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            irq_stat_q <= 8'h00;
            irq_mask_q <= 8'h00;
        end else begin
            irq_stat_q <= (irq_stat_q &
                ~((wr && addr == scc_pkg::ADDR_IRQ_STAT) ? wdata : 8'h00)) |
                {5'h00, fault_w, lk.done && !lk.abort, lk.done};
            if (wr && addr == scc_pkg::ADDR_IRQ_MASK) begin
                irq_mask_q <= wdata & scc_pkg::IRQ_IMPL_MASK;
            end
        end
    end

    assign irq = (ctrl_one_q[scc_pkg::C1_RXF_IE] &&
                  (done_flag_q || mode_fault_flag_flag_q)) ||
                 (ctrl_one_q[scc_pkg::C1_TXE_IE] && txe_flag_q) ||
                 |(irq_stat_q & irq_mask_q);

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rdata_q <= 8'h00;
        end else if (rd) begin
            case (addr)
                scc_pkg::ADDR_CTRL_ONE: rdata_q <= ctrl_one_q;
                scc_pkg::ADDR_CTRL_TWO: rdata_q <= ctrl_two_q;
                scc_pkg::ADDR_BAUD:     rdata_q <= baud_q;
                scc_pkg::ADDR_STATUS:   rdata_q <= {done_flag_q, 1'b0,
                    txe_flag_q, mode_fault_flag_flag_q, 4'h0};
                scc_pkg::ADDR_IRQ_MASK: rdata_q <= irq_mask_q;
                scc_pkg::ADDR_IRQ_STAT: rdata_q <= irq_stat_q;
                default:                rdata_q <= 8'h00;
            endcase
        end else begin
            rdata_q <= 8'h00;
        end
    end
    assign rdata = rdata_q;

    // link configuration toward shifter and divider
    assign lk.enable    = ctrl_one_q[scc_pkg::C1_EN];
    assign lk.master    = master;
    assign lk.clock_polarity      = ctrl_one_q[scc_pkg::C1_CLOCK_POLARITY];
    assign lk.clock_phase      = ctrl_one_q[scc_pkg::C1_CLOCK_PHASE];
    assign lk.lsb_first = ctrl_one_q[scc_pkg::C1_LSBF];
    assign lk.wide      = ctrl_two_q[scc_pkg::C2_WIDTH];
    assign lk.abort     = abort_w;
    assign lk.clk_run   = !(wait_mode && ctrl_two_q[scc_pkg::C2_WAITSTOP]);
    assign lk.presel    = baud_q[6:4];
    assign lk.sel       = baud_q[2:0];
    assign lk.tx_word   = tx_data;
    assign lk.tx_load   = tx_write;
    assign lk.sdi       = pinctl ? mosi_i : miso_i;
    assign rx_data      = lk.rx_word;

    scc_baud u_baud (
        .clk  (clk),
        .nrst (nrst),
        .lk   (lk)
    );

    scc_shift u_shift (
        .clk  (clk),
        .nrst (nrst),
        .lk   (lk)
    );

    always_comb begin
        mosi_oe = 1'b0;
        miso_oe = 1'b0;
        sck_oe  = 1'b0;
        if (lk.enable && master) begin
            sck_oe  = 1'b1;
            mosi_oe = pinctl ? ctrl_two_q[scc_pkg::C2_BIDIR_OUTPUT_ENABLE] : 1'b1;
        end else if (lk.enable) begin
            miso_oe = (pinctl ? ctrl_two_q[scc_pkg::C2_BIDIR_OUTPUT_ENABLE] : 1'b1) &&
                      !ssel_n_i;
        end
    end
    assign mosi_o = lk.sdo;
    assign miso_o = 1'b0;
    assign sck_o  = lk.sck_o;

    assign ssel_n_oe = lk.enable && master &&
                       ctrl_two_q[scc_pkg::C2_MODE_FAULT_ENABLE] &&
                       ctrl_one_q[scc_pkg::C1_SELECT_OUTPUT_ENABLE];
    assign ssel_n_o  = !lk.busy;

    // sck_i only matters to a slave shifter outside this block
    logic unused_sck;
    assign unused_sck = sck_i;
endmodule

// ===== scc_top_asserts.sv
// concurrent checks on the serial port control ports
`timescale 1ns/100ps
module scc_top_asserts (
    // clock and reset
    input wire logic       clk,
    input wire logic       nrst,
    // register port
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic       wr,
    input wire logic       rd,
    input wire logic [7:0] rdata,
    // system and pins
    input wire logic       wait_mode,
    input wire logic       irq,
    input wire logic       mosi_oe,
    input wire logic       miso_oe,
    input wire logic       sck_o,
    input wire logic       sck_oe,
    input wire logic       ssel_n_oe
);
    logic [7:0] c2_q;
    logic       w1;
    // shadow of control two
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst)
            c2_q <= 8'h00;
        else if (wr && addr == scc_pkg::ADDR_CTRL_TWO)
            c2_q <= wdata;
    end
    assign w1 = wr && addr == scc_pkg::ADDR_CTRL_ONE;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    AST_RD_UNMAPPED: assert property (rd && addr == 8'hee |=>
        rdata == 8'h00) else $error("unmapped read not zero");
    AST_C2_MASK: assert property (rd && addr == 8'he9 |=>
        (rdata & ~scc_pkg::C2_IMPL_MASK) == 8'h00)
        else $error("reserved control two bit set");
    AST_IRQ_GATE: assert property (w1 && !wdata[7] && !wdata[5]
        |=> !irq) else $error("irq with enables off");
    AST_OFF_PINS: assert property (w1 && !wdata[6] |=>
        !sck_oe && !mosi_oe && !ssel_n_oe) else $error("pins kept");
    AST_IDLE_LEVEL: assert property (w1 && wdata[6] && wdata[4]
        |=> ##1 sck_o == $past(wdata[3], 2)) else $error("idle level");
    AST_SSEL_OUT: assert property (ssel_n_oe |-> sck_oe &&
        (c2_q[4] || $past(c2_q[4]))) else $error("select driven");
    AST_MISO_QUIET: assert property (sck_oe |-> !miso_oe)
        else $error("master drives miso");
    AST_BIDIR_OE: assert property (mosi_oe && c2_q[0] &&
        $past(c2_q[0]) |-> c2_q[3] || $past(c2_q[3]))
        else $error("bidir out without enable");
    AST_WAIT_STOP: assert property (wait_mode &&
        $past(wait_mode) && $past(wait_mode, 2) && c2_q[1] &&
        $past(c2_q[1], 2) |-> $stable(sck_o)) else $error("wait clock");
    // main scenarios
    cover property (irq);
    cover property ($rose(ssel_n_oe));
    cover property (sck_oe && $changed(sck_o));
endmodule
bind scc_top scc_top_asserts scc_top_asserts_i (.clk(clk), .nrst(nrst),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .wait_mode(wait_mode), .irq(irq), .mosi_oe(mosi_oe),
    .miso_oe(miso_oe), .sck_o(sck_o), .sck_oe(sck_oe),
    .ssel_n_oe(ssel_n_oe));

// ===== scc_top_test.sv
// self-checking bench for the serial port control block
`timescale 1ns/100ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin fails++; \
    $display("BAD %0t got %h want %h", $time, a, b); end end
module scc_top_test;
    logic clk, nrst, wr, rd, tx_write, wait_mode, ssel_drv, clr;
    logic [7:0] addr, wdata, rdata, d;
    logic [15:0] tx_data, rx_data, s_word;
    logic irq, mosi_o, mosi_oe, miso_o, miso_oe, sck_o, sck_oe;
    logic ssel_n_o, ssel_n_oe, s_miso, m_clock_polarity, m_clock_phase, ia, ib;
    logic [31:0] rnd;
    int seed, fails, comparisons, s_cnt;
    time t0, dt;
    wire logic mosi_w = mosi_oe ? mosi_o : ~mosi_o;
    wire logic miso_w = miso_oe ? miso_o : s_miso;
    wire logic sck_w = sck_oe ? sck_o : 1'b0;
    wire logic ssel_w = ssel_n_oe ? ssel_n_o : ssel_drv;
    // clock and half period meter
    always #5 clk = ~clk;
    always @(sck_o) begin
        dt = $time - t0;
        t0 = $time;
    end
    scc_top scc_top_i (.clk(clk), .nrst(nrst), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .tx_data(tx_data), .tx_write(tx_write), .rx_data(rx_data),
        .wait_mode(wait_mode), .irq(irq), .mosi_i(mosi_w),
        .mosi_o(mosi_o), .mosi_oe(mosi_oe), .miso_i(miso_w),
        .miso_o(miso_o), .miso_oe(miso_oe), .sck_i(sck_w),
        .sck_o(sck_o), .sck_oe(sck_oe), .ssel_n_i(ssel_w),
        .ssel_n_o(ssel_n_o), .ssel_n_oe(ssel_n_oe));
    scc_slave_model scc_slave_model_i (.sck(sck_w), .mosi(mosi_w),
        .miso(s_miso), .clock_polarity(m_clock_polarity), .clock_phase(m_clock_phase), .clr(clr),
        .word(s_word), .cnt(s_cnt));
    task automatic final_report;
        $display("counts: %0d compares, %0d bad", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic wreg(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        addr  <= a;
        wdata <= v;
        wr    <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rreg(input logic [7:0] a, output logic [7:0] v);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        v = rdata;
    endtask
    // expected word as the slave assembles it
    function automatic logic [15:0] expw(input logic [15:0] w,
                                         input logic lsb, input logic wide);
        logic [15:0] r;
        int n;
        n = wide ? 16 : 8;
        r = 16'h0000;
        for (int k = 0; k < n; k++)
            r[k] = lsb ? w[n-1-k] : w[k];
        return r;
    endfunction
    // setup, clear slave, launch one word
    task automatic start(input logic [7:0] c1, input logic [7:0] c2,
                         input logic [7:0] br, input logic [15:0] w);
        wreg(scc_pkg::ADDR_BAUD, br);
        wreg(scc_pkg::ADDR_CTRL_TWO, c2);
        wreg(scc_pkg::ADDR_CTRL_ONE, c1);
        m_clock_polarity = c1[3];
        m_clock_phase = c1[2];
        clr <= 1'b1;
        @(posedge clk);
        clr      <= 1'b0;
        tx_data  <= w;
        tx_write <= 1'b1;
        @(posedge clk);
        tx_write <= 1'b0;
    endtask
    task automatic xfer(input logic [7:0] c1, input logic [7:0] c2,
                        input logic [7:0] br, input logic [15:0] w);
        logic [7:0] v;
        start(c1, c2, br, w);
        wait_mode <= c2[1];
        repeat (20) @(posedge clk);
        wait_mode <= 1'b0;
        v = 8'h00;
        for (int k = 0; k < 300 && !v[7]; k++)
            rreg(scc_pkg::ADDR_STATUS, v);
        if (!v[7]) begin
            fails++;
            final_report();
        end
        `CHK(s_cnt, c2[6] ? 16 : 8)
        `CHK(s_word, expw(w, c1[0], c2[6]))
        `CHK(dt, time'(((br[6:4] + 1) << br[2:0]) * 10))
        `CHK(sck_o, c1[3])
        // single-wire master with output on reads back its own word
        if (c2[0])
            `CHK(rx_data, c2[6] ? w : {8'h00, w[7:0]})
    endtask
    initial begin
        {clk, nrst, wr, rd, tx_write, wait_mode, clr} = 7'h00;
        {addr, wdata, tx_data, ssel_drv} = 33'h1;
        seed = 32'h7d0a;
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        rreg(scc_pkg::ADDR_CTRL_ONE, d);
        `CHK(d, scc_pkg::CTRL_ONE_RST)
        rreg(scc_pkg::ADDR_CTRL_TWO, d);
        `CHK(d, scc_pkg::CTRL_TWO_RST)
        rreg(8'hee, d);
        `CHK(d, 8'h00)
        wreg(scc_pkg::ADDR_CTRL_TWO, 8'hff);
        rreg(scc_pkg::ADDR_CTRL_TWO, d);
        `CHK(d, scc_pkg::C2_IMPL_MASK)
        wreg(scc_pkg::ADDR_BAUD, 8'hff);
        rreg(scc_pkg::ADDR_BAUD, d);
        `CHK(d, scc_pkg::BAUD_IMPL_MASK)
        $display("test registers done");
        for (int i = 0; i < 8; i++) begin
            rnd = $random(seed);
            if (i == 0)
                rnd = 32'h8001_000c;
            if (i == 1)
                rnd = 32'hff00_0033;
            xfer({4'h5, rnd[0], rnd[1], 1'b0, rnd[2]},
                 {1'b0, rnd[3], 2'h0, (rnd[6] || i == 3), 1'b0, i == 2,
                  (rnd[6] || i == 3)},
                 {3'h0, rnd[4], 3'h0, rnd[5]}, rnd[31:16]);
        end
        $display("test transfers done");
        // format change, then role change, in mid transfer
        for (int j = 0; j < 2; j++) begin
            start(8'h50, 8'h00, 8'h12, 16'h00a5);
            repeat (20) @(posedge clk);
            wreg(scc_pkg::ADDR_CTRL_ONE, j ? 8'h40 : 8'h58);
            repeat (300) @(posedge clk);
            rreg(scc_pkg::ADDR_STATUS, d);
            `CHK(d[7], 1'b0)
            `CHK(s_cnt < 8, 1'b1)
        end
        $display("test abort done");
        wreg(scc_pkg::ADDR_CTRL_ONE, 8'h10);
        rreg(scc_pkg::ADDR_STATUS, d);
        `CHK(d, 8'h00)
        `CHK(sck_oe, 1'b0)
        // pin steering: select, normal and single wire
        wreg(scc_pkg::ADDR_CTRL_ONE, 8'h52);
        for (int k = 0; k < 4; k++) begin
            wreg(scc_pkg::ADDR_CTRL_TWO, k[1] ? {4'h0, k[0], 3'h1} :
                 {3'h0, !k[0], 4'h0});
            @(posedge clk);
            #1;
            `CHK({ssel_n_oe, mosi_oe, miso_oe},
                 {k == 0, k != 2, 1'b0})
        end
        $display("test pins done");
        wreg(scc_pkg::ADDR_CTRL_ONE, 8'h50);
        wreg(scc_pkg::ADDR_CTRL_TWO, 8'h10);
        wreg(scc_pkg::ADDR_IRQ_STAT, 8'h07);
        ssel_drv <= 1'b0;
        repeat (3) @(posedge clk);
        ssel_drv <= 1'b1;
        rreg(scc_pkg::ADDR_STATUS, d);
        `CHK(d[4], 1'b1)
        rreg(scc_pkg::ADDR_CTRL_ONE, d);
        `CHK(d[4], 1'b0)
        wreg(scc_pkg::ADDR_CTRL_ONE, 8'hc0);
        wreg(scc_pkg::ADDR_IRQ_MASK, 8'h04);
        #1;
        ia = irq;
        wreg(scc_pkg::ADDR_IRQ_MASK, 8'h03);
        #1;
        ib = irq;
        `CHK(ia ^ ib, 1'b1)
        wreg(scc_pkg::ADDR_IRQ_STAT, 8'h07);
        #1;
        `CHK(irq, 1'b0)
        wreg(scc_pkg::ADDR_CTRL_ONE, 8'h60);
        #1;
        `CHK(irq, 1'b1)
        $display("test fault done");
        final_report();
    end
endmodule
